// file: logic/ppt_pkg.sv
// Package for the timing pulse and default configuration block.
// Assumes a 20 MHz pclk and a 32-bit APB register port.
package ppt_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned PPS_HIGH_MS = 100;
   localparam int unsigned PPS_PERIOD_MS = 1000;
   localparam int unsigned PPS_HIGH_CYC_DEF = CLK_HZ / 1000 * PPS_HIGH_MS;
   localparam int unsigned SEC_CYC_DEF = CLK_HZ / 1000 * PPS_PERIOD_MS;
   localparam int unsigned RTC_XTAL_HZ = 32768;
   localparam int unsigned BAUD_DEF = 9600;
   localparam logic [15:0] BAUD_DIV_DEF = 16'(CLK_HZ / BAUD_DEF);
   localparam logic [17:0] ORBIT_HORIZON_S = 18'(3 * 86400);
   localparam int unsigned FIFO_DEPTH = 32;
   localparam int unsigned DATA_BITS = 8;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_BAUD = 8'h04;
   localparam logic [7:0] ADDR_TXDATA = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_RTC = 8'h10;
   localparam logic [7:0] ADDR_LOG = 8'h14;
   localparam logic [7:0] ADDR_ORBIT = 8'h18;
   // Control field positions and reset value
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_SBAS = 2;
   localparam int unsigned CTRL_DGPS = 3;
   localparam int unsigned CTRL_ORBIT = 4;
   localparam int unsigned CTRL_RATE1HZ = 5;
   localparam logic [5:0] CTRL_RST = 6'h34;
   // Logger: cyclic, basic content, 15 s interval
   localparam logic [31:0] LOG_RST = 32'h000f_0001;
   // Pulse start modes
   localparam logic [1:0] MODE_3D = 2'h0;
   localparam logic [1:0] MODE_2D = 2'h1;
   localparam logic [1:0] MODE_PWRUP = 2'h2;
   // Fix types reported by the navigation engine
   localparam logic [1:0] FIX_NONE = 2'h0;
   localparam logic [1:0] FIX_2D = 2'h1;
   localparam logic [1:0] FIX_3D = 2'h2;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_START = 4'b0010,
      ST_DATA = 4'b0100,
      ST_STOP = 4'b1000
   } ppt_tx_state_t;
endpackage

// file: logic/ppt_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module ppt_fifo #(
   parameter int unsigned W = 8,
   parameter int unsigned D = 32
) (
   input wire logic clk, // Clock
   input wire logic rst_n, // Reset, active low
   input wire logic [W-1:0] in_data, // Write data
   input wire logic in_valid, // Write request
   output logic in_ready, // Not full
   output logic [W-1:0] out_data, // Head word
   output logic out_valid, // Not empty
   input wire logic out_ready, // Consumer takes head
   output logic [$clog2(D):0] count // Words held
);
   localparam int unsigned AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = cnt_q != (AW + 1)'(D);
   assign out_valid = cnt_q != '0;
   assign out_data = mem[rp_q];
   assign count = cnt_q;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_q] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end
endmodule

// file: logic/ppt_top.sv
// Timing pulse generator, host serial transmitter and default settings.
// Assumes fix_type from the navigation engine on pclk; nav_second, the
// 32 kHz crystal and backup_supply come from pins and are synchronised.
// Overview of operation
// - Default: pulse after 3D fix, second-aligned
// - Pulse high 100 ms, period one second
// - Optional start on 2D fix or power-up
// - Host link defaults to 9600 8N1
// - Host may raise the baud rate
// - Augmentation on by default until disabled
// - Differential input second port, off by default
// - At most one correction source applied
// - Losing all power restores every default
// - Logger defaults: cyclic, basic, 15 s
// - Orbit prediction needs backup and 1 Hz
// - Orbit prediction valid three days ahead
// - Clock counts crystal while backup present
// - Stored orbit data used once time known
`timescale 1ns/1ps
module ppt_top #(
   parameter int unsigned PPS_HIGH_CYC = ppt_pkg::PPS_HIGH_CYC_DEF, // Pulse width
   parameter int unsigned SEC_CYC = ppt_pkg::SEC_CYC_DEF, // Free-run second
   parameter int unsigned RTC_DIV = ppt_pkg::RTC_XTAL_HZ // Crystal edges per second
) (
   input wire logic pclk, // Bus clock
   input wire logic presetn, // Reset, active low
   input wire logic psel, // Select
   input wire logic penable, // Access phase
   input wire logic pwrite, // Write
   input wire logic [7:0] paddr, // Byte address
   input wire logic [31:0] pwdata, // Write data
   output logic [31:0] prdata, // Read data
   output logic pready, // Transfer done
   output logic pslverr, // Unmapped address
   input wire logic [1:0] fix_type, // Current fix
   input wire logic nav_second, // Navigation second marker pin
   input wire logic xtal_32k, // Crystal pin
   input wire logic backup_supply, // Backup supply present pin
   output logic pps, // Timing pulse
   output logic uart_tx, // Host serial output
   output logic sbas_on, // Augmentation applied
   output logic dgps_on, // Differential input on second port
   output logic orbit_pred_on, // Orbit prediction running
   output logic almanac_use // Stored orbit data in use
);
   import ppt_pkg::*;

   logic [2:0] s1_q;
   logic [2:0] s2_q;
   logic [2:0] s3_q;
   logic [2:0] flt_q;
   logic [2:0] flt_d;
   logic nav_prev_q;
   logic xtal_prev_q;
   logic nav_rise;
   logic xtal_rise;
   logic backup_f;
   logic [5:0] ctrl_q;
   logic [15:0] baud_q;
   logic [31:0] log_q;
   logic [31:0] rtc_sec_q;
   logic [31:0] rtc_div_q;
   logic rtc_valid_q;
   logic [17:0] orbit_age_q;
   logic orbit_have_q;
   logic [31:0] sec_cnt_q;
   logic [31:0] pps_cnt_q;
   logic sec_tick;
   logic armed_q;
   logic pps_q;
   logic access;
   logic wr_ok;
   logic rtc_wr;
   logic mapped;
   logic [31:0] rd_d;
   ppt_tx_state_t st_q;
   logic [15:0] bcnt_q;
   logic baud_tick;
   logic [2:0] bit_q;
   logic [7:0] sh_q;
   logic tx_q;
   logic [7:0] f_data;
   logic f_valid;
   logic f_in_ready;
   logic f_pop;
   logic [5:0] f_count;

   function automatic logic is_mapped(input logic [7:0] a);
      return a == ADDR_CTRL || a == ADDR_BAUD || a == ADDR_TXDATA || a == ADDR_STATUS
         || a == ADDR_RTC || a == ADDR_LOG || a == ADDR_ORBIT;
   endfunction

   // Three-stage pin synchronisers, a change counts once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         flt_q <= '0;
         nav_prev_q <= 1'b0;
         xtal_prev_q <= 1'b0;
      end else begin
         s1_q <= {backup_supply, xtal_32k, nav_second};
         s2_q <= s1_q;
         s3_q <= s2_q;
         flt_q <= flt_d;
         nav_prev_q <= flt_q[0];
         xtal_prev_q <= flt_q[1];
      end
   end

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         flt_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : flt_q[i];
      end
   end

   assign nav_rise = flt_q[0] && !nav_prev_q;
   assign xtal_rise = flt_q[1] && !xtal_prev_q;
   assign backup_f = flt_q[2];

   // APB slave: one wait state, TXDATA writes stall while the FIFO is full
   assign access = psel && penable && !pready;
   assign mapped = is_mapped(paddr);
   assign wr_ok = access && pwrite && mapped && (paddr != ADDR_TXDATA || f_in_ready);
   assign rtc_wr = wr_ok && paddr == ADDR_RTC;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= access && (!pwrite || paddr != ADDR_TXDATA || f_in_ready || !mapped);
         pslverr <= access && !mapped;
         if (access && !pwrite) begin
            prdata <= rd_d;
         end
      end
   end

   always_comb begin
      rd_d = '0;
      case (paddr)
         ADDR_CTRL: rd_d = {26'h0, ctrl_q};
         ADDR_BAUD: rd_d = {16'h0, baud_q};
         ADDR_TXDATA: rd_d = {26'h0, f_count};
         ADDR_STATUS: rd_d = {24'h0, fix_type, rtc_valid_q, !f_valid, !f_in_ready,
            orbit_have_q, backup_f, armed_q};
         ADDR_RTC: rd_d = rtc_sec_q;
         ADDR_LOG: rd_d = log_q;
         ADDR_ORBIT: rd_d = {14'h0, orbit_age_q};
         default: rd_d = '0;
      endcase
   end

   // Configuration, all back to defaults on reset (loss of all supplies)
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RST;
         baud_q <= BAUD_DIV_DEF;
         log_q <= LOG_RST;
      end else if (wr_ok) begin
         case (paddr)
            ADDR_CTRL: ctrl_q <= pwdata[5:0];
            ADDR_BAUD: begin
               // Only rates at or above the default are taken
               if (pwdata[15:0] != 16'h0 && pwdata[15:0] <= BAUD_DIV_DEF) begin
                  baud_q <= pwdata[15:0];
               end
            end
            ADDR_LOG: log_q <= pwdata;
            default: ;
         endcase
      end
   end

   // Correction source selection, differential input overrides augmentation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sbas_on <= 1'b0;
         dgps_on <= 1'b0;
      end else begin
         sbas_on <= ctrl_q[CTRL_SBAS] && !ctrl_q[CTRL_DGPS];
         dgps_on <= ctrl_q[CTRL_DGPS];
      end
   end

   chk_corr_excl: assert property (@(posedge pclk) disable iff (!presetn)
      !(sbas_on && dgps_on))
      else $error("both correction sources applied");

   // Real-time clock from crystal edges, runs only with backup present
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rtc_div_q <= '0;
         rtc_sec_q <= '0;
         rtc_valid_q <= 1'b0;
      end else begin
         if (rtc_wr) begin
            rtc_sec_q <= pwdata;
            rtc_div_q <= '0;
         end else if (backup_f && xtal_rise) begin
            if (rtc_div_q == RTC_DIV - 1) begin
               rtc_div_q <= '0;
               rtc_sec_q <= rtc_sec_q + 1'b1;
            end else begin
               rtc_div_q <= rtc_div_q + 1'b1;
            end
         end
         if (rtc_wr || fix_type == FIX_3D) begin
            rtc_valid_q <= 1'b1;
         end
      end
   end

   chk_rtc_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !backup_f && !rtc_wr |=> $stable(rtc_sec_q))
      else $error("clock advanced without backup supply");

   // Orbit prediction: age since last 3D fix, valid up to the horizon
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         orbit_age_q <= '0;
         orbit_have_q <= 1'b0;
         orbit_pred_on <= 1'b0;
         almanac_use <= 1'b0;
      end else begin
         if (fix_type == FIX_3D) begin
            orbit_age_q <= '0;
            orbit_have_q <= 1'b1;
         end else if (!backup_f) begin
            orbit_have_q <= 1'b0;
         end else if (orbit_have_q && sec_tick) begin
            if (orbit_age_q == ORBIT_HORIZON_S - 1'b1) begin
               orbit_have_q <= 1'b0;
            end
            orbit_age_q <= orbit_age_q + 1'b1;
         end
         orbit_pred_on <= ctrl_q[CTRL_ORBIT] && ctrl_q[CTRL_RATE1HZ]
            && backup_f && orbit_have_q;
         almanac_use <= rtc_valid_q;
      end
   end

   chk_orbit_cond: assert property (@(posedge pclk) disable iff (!presetn)
      orbit_pred_on |-> $past(backup_f) && $past(ctrl_q[CTRL_RATE1HZ]))
      else $error("orbit prediction without backup or 1 Hz");

   // One-second base, realigned by the navigation second marker
   assign sec_tick = nav_rise || sec_cnt_q == SEC_CYC - 1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_cnt_q <= '0;
         armed_q <= 1'b0;
      end else begin
         sec_cnt_q <= sec_tick ? '0 : sec_cnt_q + 1'b1;
         case (ctrl_q[1:0])
            MODE_3D: armed_q <= fix_type == FIX_3D;
            MODE_2D: armed_q <= fix_type == FIX_3D || fix_type == FIX_2D;
            MODE_PWRUP: armed_q <= 1'b1;
            default: armed_q <= fix_type == FIX_3D;
         endcase
      end
   end

   // Timing pulse: rises on the second tick once armed, falls after the width
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pps_q <= 1'b0;
         pps_cnt_q <= '0;
      end else if (sec_tick && armed_q) begin
         pps_q <= 1'b1;
         pps_cnt_q <= '0;
      end else if (pps_q) begin
         if (pps_cnt_q == PPS_HIGH_CYC - 1) begin
            pps_q <= 1'b0;
         end
         pps_cnt_q <= pps_cnt_q + 1'b1;
      end else if (!armed_q) begin
         pps_q <= 1'b0;
      end
   end

   assign pps = pps_q;

   logic [31:0] hi_len_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_len_q <= '0;
      end else begin
         hi_len_q <= pps_q ? hi_len_q + 1'b1 : '0;
      end
   end

   sequence s_edge_armed;
      nav_rise && armed_q && ctrl_q[1:0] == MODE_3D;
   endsequence

   chk_pps_align: assert property (@(posedge pclk) disable iff (!presetn)
      s_edge_armed |=> pps_q && pps_cnt_q == 32'h0)
      else $error("pulse not aligned to navigation second");

   chk_pps_width: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(pps_q) |-> hi_len_q == PPS_HIGH_CYC)
      else $error("pulse width wrong");

   chk_pps_gated: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(pps_q) |-> $past(armed_q))
      else $error("pulse started before fix condition");

   // Host serial transmitter, 8 data bits, no parity, one stop bit
   ppt_fifo #(.W(DATA_BITS), .D(FIFO_DEPTH)) u_fifo (
      .clk(pclk),
      .rst_n(presetn),
      .in_data(pwdata[7:0]),
      .in_valid(wr_ok && paddr == ADDR_TXDATA),
      .in_ready(f_in_ready),
      .out_data(f_data),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .count(f_count)
   );

   assign f_pop = st_q == ST_IDLE && f_valid;
   // Compare with >= so that a rate change in mid-bit cannot run the counter past
   // the new divisor and stretch that bit to a full counter wrap
   assign baud_tick = st_q != ST_IDLE && bcnt_q >= baud_q - 1'b1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bcnt_q <= '0;
      end else begin
         bcnt_q <= (st_q == ST_IDLE || baud_tick) ? '0 : bcnt_q + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_IDLE;
         bit_q <= '0;
         sh_q <= '0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (f_valid) begin
                  sh_q <= f_data;
                  st_q <= ST_START;
               end
            end
            ST_START: begin
               if (baud_tick) begin
                  bit_q <= '0;
                  st_q <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (baud_tick) begin
                  sh_q <= {1'b0, sh_q[7:1]};
                  bit_q <= bit_q + 1'b1;
                  if (bit_q == 3'h7) begin
                     st_q <= ST_STOP;
                  end
               end
            end
            ST_STOP: begin
               if (baud_tick) begin
                  st_q <= ST_IDLE;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_q <= 1'b1;
      end else begin
         case (st_q)
            ST_START: tx_q <= 1'b0;
            ST_DATA: tx_q <= sh_q[0];
            default: tx_q <= 1'b1;
         endcase
      end
   end

   assign uart_tx = tx_q;

   sequence s_start_done;
      st_q == ST_START && baud_tick;
   endsequence

   chk_tx_frame: assert property (@(posedge pclk) disable iff (!presetn)
      s_start_done |=> st_q == ST_DATA && bit_q == 3'h0 && !tx_q)
      else $error("start bit not followed by data");

   chk_baud_range: assert property (@(posedge pclk) disable iff (!presetn)
      baud_q != 16'h0 && baud_q <= BAUD_DIV_DEF)
      else $error("baud divisor outside allowed range");
endmodule

// file: dv/ppt_host_rx.sv
// Host side of the serial link: receives 8N1 frames from the device.
// Assumes the bench sets div to the divisor it has programmed.
`timescale 1ns/1ps
module ppt_host_rx (
   input wire logic clk, // Bus clock
   input wire logic rxd, // Device serial output
   input wire logic [15:0] div, // Cycles per bit
   output logic [7:0] rx_data, // Received byte
   output logic rx_stb, // One cycle per frame
   output logic rx_err // Stop bit was low
);
   logic [7:0] b;
   initial begin
      rx_data = 8'h00;
      rx_stb = 1'b0;
      rx_err = 1'b0;
   end
   always begin
      @(negedge rxd);
      repeat (div / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (div) @(posedge clk);
         b[i] = rxd;
      end
      repeat (div) @(posedge clk);
      rx_err <= (rxd !== 1'b1);
      rx_data <= b;
      rx_stb <= 1'b1;
      @(posedge clk);
      rx_stb <= 1'b0;
   end
endmodule

// file: dv/ppt_top_tb.sv
// Bench for ppt_top: APB master, pin stimulus, host receiver, scoreboard.
// Assumes shortened pulse, second and crystal counts set below.
`timescale 1ns/1ps
module ppt_top_tb;
   import ppt_pkg::*;
   localparam int HI = 20;
   localparam int SEC = 200;
   localparam int NAVP = 150;
   typedef struct {string nm; logic [31:0] v; logic chk; logic err;} ppt_exp_t;
   localparam logic [1:0] MD[5] = '{MODE_3D, MODE_3D, MODE_2D, MODE_3D, MODE_PWRUP};
   localparam logic [1:0] FX[5] = '{FIX_NONE, FIX_2D, FIX_2D, FIX_3D, FIX_NONE};
   localparam bit ACT[5] = '{0, 0, 1, 1, 1};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, nav_second, xtal_32k;
   logic backup_supply, pps, uart_tx, sbas_on, dgps_on, orbit_pred_on, almanac_use;
   logic rx_stb, rx_err;
   logic [7:0] paddr, rx_data;
   logic [31:0] pwdata, prdata, rd_v, rs;
   logic [1:0] fix_type;
   logic [15:0] host_div;
   ppt_exp_t eq[$];
   ppt_exp_t e;
   logic [7:0] uq[$];
   int n_mismatch, cmp_count, max_wait, hi_n, per_n, nav_cnt, xt_cnt;
   ppt_top #(.PPS_HIGH_CYC(HI), .SEC_CYC(SEC), .RTC_DIV(4)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fix_type(fix_type), .nav_second(nav_second), .xtal_32k(xtal_32k),
      .backup_supply(backup_supply), .pps(pps), .uart_tx(uart_tx), .sbas_on(sbas_on),
      .dgps_on(dgps_on), .orbit_pred_on(orbit_pred_on), .almanac_use(almanac_use)
   );
   ppt_host_rx u_host (
      .clk(pclk), .rxd(uart_tx), .div(host_div), .rx_data(rx_data), .rx_stb(rx_stb),
      .rx_err(rx_err)
   );
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // Navigation second marker faster than the free-run second; crystal stand-in
   always @(posedge pclk) begin
      nav_cnt <= (nav_cnt == NAVP - 1) ? 0 : nav_cnt + 1;
      nav_second <= (nav_cnt < 3);
      xt_cnt <= (xt_cnt == 6) ? 0 : xt_cnt + 1;
      if (xt_cnt == 6) begin
         xtal_32k <= ~xtal_32k;
      end
   end
   task automatic final_report;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic timeout(input string nm);
      n_mismatch++;
      $display("wait for %s ran out", nm);
      final_report();
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && eq.size() > 0) begin
         e = eq.pop_front();
         if (e.chk) check(e.nm, prdata, e.v);
         check({e.nm, " err"}, 32'(pslverr), 32'(e.err));
      end
      if (rx_stb === 1'b1) begin
         check("rx byte", 32'(rx_data), (uq.size() > 0) ? 32'(uq.pop_front()) : 32'hx);
         check("rx stop", 32'(rx_err), 32'h0);
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 5000);
      if (n >= 5000) timeout("pready");
      if (n > max_wait) max_wait = n;
      rd_v = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] v, input string nm,
      input logic chk, input logic err);
      eq.push_back('{nm, v, chk, err});
      apb(1'b0, a, 32'h0);
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic pps_meas(input bit act, output int hi, output int per);
      int n;
      n = 0;
      hi = 0;
      while (pps === 1'b1 && n < 400) begin
         @(posedge pclk);
         n++;
      end
      while (pps !== 1'b1 && n < 800) begin
         @(posedge pclk);
         n++;
      end
      while (pps === 1'b1 && hi < 400) begin
         @(posedge pclk);
         hi++;
      end
      per = hi;
      while (pps !== 1'b1 && per < 400) begin
         @(posedge pclk);
         per++;
      end
      if (act && (n >= 800 || hi >= 400 || per >= 400)) timeout("pps");
   endtask
   task automatic wait_q;
      int n;
      n = 0;
      while (uq.size() > 0 && n < 40000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 40000) timeout("serial");
   endtask
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fix_type = FIX_NONE;
      nav_second = 1'b0;
      xtal_32k = 1'b0;
      backup_supply = 1'b1;
      host_div = BAUD_DIV_DEF;
      rs = 32'd46;
      cycles(5);
      presetn <= 1'b1;
      rd(ADDR_CTRL, 32'(CTRL_RST), "ctrl", 1, 0);
      rd(ADDR_BAUD, 32'(BAUD_DIV_DEF), "baud", 1, 0);
      rd(ADDR_LOG, LOG_RST, "log", 1, 0);
      rd(8'h40, 32'h0, "unmapped", 0, 1);
      check("sbas", 32'(sbas_on), 32'h1);
      check("dgps", 32'(dgps_on), 32'h0);
      $display("test defaults done");
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, ADDR_CTRL, {26'h0, CTRL_RST[5:2], MD[i]});
         fix_type <= FX[i];
         cycles(SEC);
         pps_meas(ACT[i], hi_n, per_n);
         if (!ACT[i]) check("pps idle", 32'(pps), 32'h0);
         check("pps high", 32'(hi_n), ACT[i] ? 32'(HI) : 32'h0);
         if (ACT[i]) check("pps period", 32'(per_n), 32'(NAVP));
      end
      $display("test pulse modes done");
      apb(1'b1, ADDR_CTRL, 32'h3c);
      cycles(3);
      check("sbas both", 32'(sbas_on), 32'h0);
      check("dgps both", 32'(dgps_on), 32'h1);
      apb(1'b1, ADDR_CTRL, 32'h30);
      cycles(3);
      check("sbas off", 32'(sbas_on), 32'h0);
      apb(1'b1, ADDR_CTRL, 32'(CTRL_RST));
      fix_type <= FIX_3D;
      cycles(10);
      check("orbit on", 32'(orbit_pred_on), 32'h1);
      check("almanac", 32'(almanac_use), 32'h1);
      backup_supply <= 1'b0;
      cycles(10);
      check("orbit nobackup", 32'(orbit_pred_on), 32'h0);
      apb(1'b1, ADDR_RTC, 32'h7);
      cycles(100);
      rd(ADDR_RTC, 32'h7, "rtc hold", 1, 0);
      backup_supply <= 1'b1;
      cycles(200);
      rd(ADDR_RTC, 32'h0, "rtc", 0, 0);
      check("rtc runs", 32'(rd_v != 32'h7), 32'h1);
      apb(1'b1, ADDR_CTRL, 32'h14);
      cycles(10);
      check("orbit rate", 32'(orbit_pred_on), 32'h0);
      $display("test corrections and backup done");
      uq.push_back(8'ha5);
      apb(1'b1, ADDR_TXDATA, 32'ha5);
      wait_q();
      // Let the stop bit finish before the rate changes on both sides
      cycles(int'(BAUD_DIV_DEF));
      apb(1'b1, ADDR_BAUD, 32'd16);
      apb(1'b1, ADDR_BAUD, 32'd0);
      apb(1'b1, ADDR_BAUD, 32'd3000);
      rd(ADDR_BAUD, 32'd16, "baud set", 1, 0);
      host_div <= 16'd16;
      max_wait = 0;
      for (int i = 0; i < 40; i++) begin
         rs = xs(rs);
         uq.push_back(rs[7:0]);
         apb(1'b1, ADDR_TXDATA, {24'h0, rs[7:0]});
      end
      check("fifo stall", 32'(max_wait > 40), 32'h1);
      wait_q();
      rd(ADDR_TXDATA, 32'h0, "fifo count", 1, 0);
      $display("test serial done");
      apb(1'b1, ADDR_CTRL, 32'h0b);
      apb(1'b1, ADDR_LOG, 32'h1);
      presetn <= 1'b0;
      cycles(5);
      presetn <= 1'b1;
      host_div <= BAUD_DIV_DEF;
      rd(ADDR_CTRL, 32'(CTRL_RST), "ctrl again", 1, 0);
      rd(ADDR_BAUD, 32'(BAUD_DIV_DEF), "baud again", 1, 0);
      rd(ADDR_LOG, LOG_RST, "log again", 1, 0);
      check("sbas again", 32'(sbas_on), 32'h1);
      $display("test power loss done");
      final_report();
   end
endmodule
